/* File: src/utd_td_core.sv */
`timescale 1ns/1ps
module utd_td_core #(
  parameter int LEN_W = 11
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic low_speed,
  input wire logic halt_clear,
  input wire logic td_load,
  input wire logic [31:0] td_token,
  input wire logic [31:0] td_buffer,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  input wire logic tx_ready,
  input wire logic tx_starved,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_crc_err,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic line_eop_end,
  input wire logic line_sop,
  input wire logic xact_done,
  output logic busy,
  output logic token_valid,
  output logic [7:0] token_pid,
  output logic [6:0] token_addr,
  output logic [3:0] token_endp,
  output logic [7:0] data_pid,
  output logic consist_fail,
  output logic halted,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic mem_wr_req,
  output logic [31:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic status_wr,
  output logic [31:0] status_word
);
  import utd_pkg::*;

  // ----------------------------------------------------------------
  // Token field decode
  // ----------------------------------------------------------------
  wire [LEN_W-1:0] tok_len = td_token[MAXIMUM_LENGTH_HI:MAXIMUM_LENGTH_LO];
  wire [7:0] tok_pid = td_token[PID_HI:PID_LO];
  wire pid_known = (tok_pid == PID_IN) || (tok_pid == PID_OUT)
                   || (tok_pid == PID_SETUP);
  // Complement check is redundant for the three codes but kept explicit
  wire pid_pair_ok = (tok_pid[3:0] == ~tok_pid[7:4]);
  wire pid_ok = pid_known && pid_pair_ok;
  wire len_bad = (tok_len >= LEN_ILLEGAL_LO) && (tok_len <= LEN_ILLEGAL_HI);
  wire len_null = (tok_len == LEN_NULL);
  // Payload bytes only; protocol bytes never enter this count
  wire [LEN_W:0] len_bytes = len_null ? '0 : ({1'b0, tok_len} + 12'h001);
  wire tok_is_in = (tok_pid == PID_IN);
  wire tok_ok = pid_ok && !len_bad;

  // ----------------------------------------------------------------
  // Bit-time divider, full or low speed
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  wire [7:0] div_end = low_speed ? 8'(LS_BIT_CYC - 1) : 8'(FS_BIT_CYC - 1);
  wire bit_tick = (div_q >= div_end);

  // Free running; only the turnaround timer consumes the tick
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= bit_tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Line checkers
  // ----------------------------------------------------------------
  logic stuff_err;
  logic turn_to;
  logic line_clear; // Any load taken while idle and not halted, bad token or not; a load while busy or halted does not wipe the flags

  utd_stuff_chk #(
    .RUN_MAX(STUFF_RUN_MAX)
  ) u_stuff (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clear(line_clear),
    .bit_valid(rx_bit_valid),
    .bit_val(rx_bit),
    .stuff_err(stuff_err)
  );

  utd_turnaround #(
    .MAX_BITS(TURN_MAX_BITS)
  ) u_turn (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clear(line_clear),
    .bit_tick(bit_tick),
    .eop_end(line_eop_end),
    .sop_seen(line_sop),
    .timeout(turn_to)
  );

  // ----------------------------------------------------------------
  // Transaction state
  // ----------------------------------------------------------------
  utd_state_e state_q;
  utd_state_e state_d;
  logic [LEN_W:0] limit_q; // Payload bytes allowed this transaction
  logic [LEN_W:0] moved_q; // Payload bytes actually moved
  logic [31:0] base_q; // Buffer start, any byte alignment
  logic crc_q; // Receive CRC error seen
  logic halt_q;
  logic fail_q;

  wire at_limit = (moved_q == limit_q);
  wire active = (state_q != UTD_IDLE);
  wire start = td_load && !active && !halt_q;
  assign line_clear = start;
  // Address of the next byte: plain byte add, no alignment forced
  wire [31:0] next_addr = base_q + 32'(moved_q);
  wire take_rx = (state_q == UTD_RECV) && rx_byte_valid && !at_limit;
  wire take_tx = (state_q == UTD_SEND) && tx_valid && tx_ready;
  wire got_fetch = (state_q == UTD_FETCH) && mem_rd_ack;

  // Next-state selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      UTD_IDLE: begin
        if (start && tok_ok) begin
          if (tok_is_in) begin
            state_d = UTD_RECV;
          end else if (len_null) begin
            state_d = UTD_WAIT;
          end else begin
            state_d = UTD_FETCH;
          end
        end
      end
      UTD_FETCH: begin
        // Latency starvation abandons the rest of the payload
        if (tx_starved) begin
          state_d = UTD_WAIT;
        end else if (mem_rd_ack) begin
          state_d = UTD_SEND;
        end
      end
      UTD_SEND: begin
        if (take_tx) begin
          // Terminal count reached: no further memory reads
          state_d = (moved_q + 12'h001 == limit_q) ? UTD_WAIT : UTD_FETCH;
        end
      end
      UTD_RECV: begin
        state_d = UTD_RECV;
      end
      UTD_WAIT: begin
        state_d = UTD_WAIT;
      end
      default: begin
        state_d = UTD_IDLE;
      end
    endcase
    if (active && xact_done) begin
      state_d = UTD_IDLE;
    end
  end

  // State and counters
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= UTD_IDLE;
      limit_q <= '0;
      moved_q <= '0;
      base_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (start) begin
        limit_q <= len_bytes;
        moved_q <= '0;
        base_q <= td_buffer;
      end else if (take_tx || take_rx) begin
        moved_q <= moved_q + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Consistency check and halt
  // ----------------------------------------------------------------
  // Halt holds until the controller is restarted; a fresh failure in the
  // restart cycle is kept
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (start && !tok_ok) begin
        halt_q <= 1'b1;
        fail_q <= 1'b1;
      end else if (halt_clear) begin
        halt_q <= 1'b0;
        fail_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Token packet fields
  // ----------------------------------------------------------------
  // Reserved token bit 20 is never looked at
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      token_valid <= 1'b0;
      token_pid <= 8'h00;
      token_addr <= 7'h00;
      token_endp <= 4'h0;
      data_pid <= PID_DATA0;
    end else begin
      token_valid <= start && tok_ok;
      if (start && tok_ok) begin
        token_pid <= tok_pid;
        token_addr <= td_token[ADDR_HI:ADDR_LO];
        token_endp <= td_token[ENDP_HI:ENDP_LO];
        data_pid <= td_token[TOGGLE_BIT] ? PID_DATA1 : PID_DATA0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory read and transmit path
  // ----------------------------------------------------------------
  // One byte in flight at a time; simple but leaves no prefetch slack
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rd_req <= 1'b0;
      mem_rd_addr <= 32'h0000_0000;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      mem_rd_req <= (state_d == UTD_FETCH) && !got_fetch;
      if (state_d == UTD_FETCH) begin
        mem_rd_addr <= (start) ? td_buffer : (take_tx ? next_addr + 32'h1 : next_addr);
      end
      if (got_fetch && !tx_starved) begin
        tx_valid <= 1'b1;
        tx_byte <= mem_rd_data;
      end else if (take_tx || xact_done) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive and memory write path
  // ----------------------------------------------------------------
  // Bytes beyond the allowed count are dropped, never written past it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_wr_req <= 1'b0;
      mem_wr_addr <= 32'h0000_0000;
      mem_wr_data <= 8'h00;
      crc_q <= 1'b0;
    end else begin
      mem_wr_req <= take_rx;
      if (take_rx) begin
        mem_wr_addr <= next_addr;
        mem_wr_data <= rx_byte;
      end
      if (state_q == UTD_RECV && rx_crc_err) begin
        crc_q <= 1'b1;
      end else if (start) begin
        crc_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status write-back
  // ----------------------------------------------------------------
  // Count minus one wraps zero bytes to the null code naturally
  wire [LEN_W-1:0] act_len = LEN_W'(moved_q - 12'h001);
  wire crc_tout = crc_q || (state_q == UTD_RECV && rx_crc_err) || turn_to;

  // Reserved bits 15:11 stay zero; earlier status bits belong elsewhere
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_wr <= 1'b0;
      status_word <= 32'h0000_0000;
    end else begin
      status_wr <= active && xact_done;
      if (active && xact_done) begin
        status_word <= 32'h0000_0000;
        status_word[ST_ACTUAL_LENGTH_HI:ST_ACTUAL_LENGTH_LO] <= act_len;
        status_word[ST_STUFF_BIT] <= stuff_err;
        status_word[ST_TURN_BIT] <= turn_to;
        status_word[ST_CRC_TOUT_BIT] <= crc_tout;
      end
    end
  end

  // ----------------------------------------------------------------
  // Visible state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      consist_fail <= 1'b0;
      halted <= 1'b0;
    end else begin
      busy <= (state_d != UTD_IDLE);
      consist_fail <= fail_q;
      halted <= halt_q;
    end
  end

endmodule

/* File: src/utd_pkg.sv */
package utd_pkg;

  // ----------------------------------------------------------------
  // Token word field layout
  // ----------------------------------------------------------------
  localparam int MAXIMUM_LENGTH_HI = 31;
  localparam int MAXIMUM_LENGTH_LO = 21;
  localparam int TOGGLE_BIT = 19;
  localparam int ENDP_HI = 18;
  localparam int ENDP_LO = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int PID_HI = 7;
  localparam int PID_LO = 0;

  // ----------------------------------------------------------------
  // Status word field layout
  // ----------------------------------------------------------------
  localparam int ST_CRC_TOUT_BIT = 18;
  localparam int ST_STUFF_BIT = 17;
  localparam int ST_TURN_BIT = 16;
  localparam int ST_ACTUAL_LENGTH_HI = 10;
  localparam int ST_ACTUAL_LENGTH_LO = 0;

  // ----------------------------------------------------------------
  // Length encoding
  // ----------------------------------------------------------------
  localparam logic [10:0] LEN_MAX_LEGAL = 11'h4ff;
  localparam logic [10:0] LEN_NULL = 11'h7ff;
  localparam logic [10:0] LEN_ILLEGAL_LO = 11'h500;
  localparam logic [10:0] LEN_ILLEGAL_HI = 11'h7fe;
  localparam logic [10:0] LEN_RESET = 11'h000;

  // ----------------------------------------------------------------
  // Packet identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0] PID_IN = 8'h69;
  localparam logic [7:0] PID_OUT = 8'he1;
  localparam logic [7:0] PID_SETUP = 8'h2d;
  localparam logic [7:0] PID_DATA0 = 8'hc3;
  localparam logic [7:0] PID_DATA1 = 8'h4b;

  // ----------------------------------------------------------------
  // Line timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int FS_BIT_HZ = 12_000_000;
  localparam int LS_BIT_HZ = 1_500_000;
  localparam int FS_BIT_CYC = CLK_HZ / FS_BIT_HZ;
  localparam int LS_BIT_CYC = CLK_HZ / LS_BIT_HZ;
  localparam int STUFF_RUN_MAX = 6;
  localparam int TURN_MIN_BITS = 16;
  localparam int TURN_MAX_BITS = 18;

  // ----------------------------------------------------------------
  // Transaction engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UTD_IDLE,
    UTD_FETCH,
    UTD_SEND,
    UTD_RECV,
    UTD_WAIT
  } utd_state_e;

endpackage

/* File: src/utd_stuff_chk.sv */
`timescale 1ns/1ps
module utd_stuff_chk #(
  parameter int RUN_MAX = 6
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_val,
  output logic stuff_err
);

  // ----------------------------------------------------------------
  // Run counter of consecutive ones
  // ----------------------------------------------------------------
  logic [3:0] run_q;
  logic err_q;
  wire run_over = bit_valid && bit_val && (run_q == 4'(RUN_MAX));

  // Counter saturates at RUN_MAX; a zero restarts the run
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 4'h0;
      err_q <= 1'b0;
    end else begin
      if (clear) begin
        run_q <= 4'h0;
      end else if (bit_valid) begin
        run_q <= bit_val ? ((run_q == 4'(RUN_MAX)) ? run_q : run_q + 4'h1) : 4'h0;
      end
      // Set beats clear so a seventh one in the clear cycle is kept
      if (run_over) begin
        err_q <= 1'b1;
      end else if (clear) begin
        err_q <= 1'b0;
      end
    end
  end

  assign stuff_err = err_q;

endmodule

/* File: src/utd_turnaround.sv */
`timescale 1ns/1ps
module utd_turnaround #(
  parameter int MAX_BITS = 18
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic bit_tick,
  input wire logic eop_end,
  input wire logic sop_seen,
  output logic timeout
);

  // ----------------------------------------------------------------
  // Bit-time counter armed by the end of the previous packet
  // ----------------------------------------------------------------
  logic armed_q;
  logic [4:0] cnt_q;
  logic to_q;
  wire expire = armed_q && bit_tick && (cnt_q == 5'(MAX_BITS - 1));

  // A start of packet disarms; the window ends at the last allowed bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
      cnt_q <= 5'h00;
      to_q <= 1'b0;
    end else begin
      if (eop_end) begin
        armed_q <= 1'b1;
        cnt_q <= 5'h00;
      end else if (sop_seen || expire) begin
        armed_q <= 1'b0;
      end else if (armed_q && bit_tick) begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (expire && !sop_seen) begin
        to_q <= 1'b1;
      end else if (clear) begin
        to_q <= 1'b0;
      end
    end
  end

  assign timeout = to_q;

endmodule

/* File: verif/utd_td_core_chk.sv */
`timescale 1ns/1ps
module utd_td_core_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic td_load,
  input wire logic [31:0] td_token,
  input wire logic [31:0] td_buffer,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic xact_done,
  input wire logic busy,
  input wire logic token_valid,
  input wire logic [7:0] token_pid,
  input wire logic [6:0] token_addr,
  input wire logic [3:0] token_endp,
  input wire logic [7:0] data_pid,
  input wire logic consist_fail,
  input wire logic halted,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic mem_wr_req,
  input wire logic [7:0] mem_wr_data,
  input wire logic status_wr,
  input wire logic [31:0] status_word
);
  import utd_pkg::*;
  // ------------------------------------------------------------
  // Token decode seen from outside
  // ------------------------------------------------------------
  // Only three identifiers are legal
  wire pid_ok = td_token[7:0] inside {PID_IN, PID_OUT, PID_SETUP};
  // Length codes in the hole between 1280 bytes and null
  wire len_bad = td_token[31:21] >= LEN_ILLEGAL_LO && td_token[31:21] <= LEN_ILLEGAL_HI;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Load the core must take
  sequence s_take;
    td_load && !busy && !halted;
  endsequence
  // Taken load with a sound token
  sequence s_good;
    s_take ##0 (pid_ok && !len_bad);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  tok_echo_a:
    assert property (s_good |=> token_valid && token_pid == $past(td_token[7:0]))
    else $error("token pid not echoed");
  tok_target_a:
    assert property (token_valid |-> token_addr == $past(td_token[14:8])
      && token_endp == $past(td_token[18:15])) else $error("token target wrong");
  tok_toggle_a:
    assert property (token_valid |-> data_pid == ($past(td_token[19]) ? PID_DATA1 : PID_DATA0))
    else $error("data pid wrong");
  pid_halt_a:
    assert property (s_take ##0 !pid_ok |-> ##2 (halted && consist_fail))
    else $error("bad pid did not halt");
  len_halt_a:
    assert property (s_take ##0 len_bad |=> !token_valid ##1 (halted && consist_fail))
    else $error("illegal length did not halt");
  rd_start_a:
    assert property (token_valid && mem_rd_req |-> mem_rd_addr == $past(td_buffer))
    else $error("fetch start address wrong");
  wr_echo_a:
    assert property (mem_wr_req |-> $past(rx_byte_valid) && mem_wr_data == $past(rx_byte))
    else $error("write data not received byte");
  st_zero_a:
    assert property (status_wr |-> status_word[31:19] == 13'h0 && status_word[15:11] == 5'h0)
    else $error("reserved status bits set");
  st_when_a:
    assert property (status_wr |-> $past(xact_done) && $past(busy) && !busy)
    else $error("status write out of turn");
endmodule

bind utd_td_core utd_td_core_chk utd_td_core_chk_inst (.*);

/* File: verif/utd_func_model.sv */
`timescale 1ns/1ps
module utd_func_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic token_valid,
  input wire logic [31:0] exp_base,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic mem_rd_ack,
  output logic [7:0] mem_rd_data,
  output logic tx_ready,
  output logic [15:0] tx_count,
  output logic [15:0] tx_bad
);
  // ------------------------------------------------------------
  // Memory and far-end transmitter
  // ------------------------------------------------------------
  logic slow_q; // Alternates prompt and late answers
  logic [31:0] base_q; // Buffer start of this descriptor
  wire take = tx_valid && tx_ready;
  // Byte expected next, from start address and count
  wire [31:0] exp_addr = base_q + 32'(tx_count);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= 8'h00;
      tx_ready <= 1'b0;
      slow_q <= 1'b0;
      base_q <= 32'h0;
      tx_count <= 16'h0;
      tx_bad <= 16'h0;
    end else begin
      mem_rd_ack <= 1'b0;
      // Released data bus keeps changing so stale bytes are caught
      mem_rd_data <= ~mem_rd_data;
      // Stall the transmitter every other cycle
      tx_ready <= ~tx_ready;
      if (mem_rd_req && !mem_rd_ack) begin
        slow_q <= ~slow_q;
        // Any byte address is backed by memory
        if (mem_rd_addr[0] || slow_q) begin
          mem_rd_ack <= 1'b1;
          mem_rd_data <= mem_rd_addr[7:0] ^ 8'h5a;
        end
      end
      if (token_valid) begin
        base_q <= exp_base;
        tx_count <= 16'h0;
      end else if (take) begin
        tx_count <= tx_count + 16'h1;
        // Bytes must leave in address order
        if (tx_byte !== (exp_addr[7:0] ^ 8'h5a)) begin
          tx_bad <= tx_bad + 16'h1;
        end
      end
    end
  end
endmodule

/* File: verif/test_utd_td_core.sv */
`timescale 1ns/1ps
module test_utd_td_core;
  import utd_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk, arst_n, low_speed, td_load, rx_byte_valid, rx_bit_valid, rx_bit;
  logic busy, token_valid, consist_fail, halted, mem_rd_req, tx_valid, mem_wr_req;
  logic status_wr, mem_rd_ack, tx_ready;
  logic [31:0] td_token, td_buffer, mem_rd_addr, mem_wr_addr, status_word;
  logic [7:0] rx_byte, token_pid, data_pid, tx_byte, mem_wr_data, mem_rd_data;
  logic [6:0] token_addr;
  logic [3:0] token_endp;
  logic [15:0] tx_count, tx_bad;
  logic [5:0] pv; // Pulses: eop end, sop, crc, halt clear, done, starved
  int bad_count = 0;
  int n_compared = 0;
  int wr_cnt = 0;
  // Transmit cases: two bytes odd start, one byte at top, null packet
  logic [7:0] op_pid [3] = '{PID_OUT, PID_SETUP, PID_OUT};
  logic [10:0] op_len [3] = '{11'h001, 11'h000, LEN_NULL};
  logic [31:0] op_buf [3] = '{32'h1000_0003, 32'hffff_ffff, 32'h0000_0040};
  logic [15:0] op_n [3] = '{16'd2, 16'd1, 16'd0};
  // Refused tokens: foreign identifiers and illegal lengths
  logic [7:0] bad_pid [6] = '{8'h00, 8'ha5, 8'he2, 8'h96, PID_IN, PID_IN};
  logic [10:0] bad_len [6] = '{11'h0, 11'h0, 11'h0, 11'h0, LEN_ILLEGAL_LO, LEN_ILLEGAL_HI};

  utd_td_core utd_td_core_inst (.*, .tx_starved(pv[5]), .line_eop_end(pv[0]),
    .line_sop(pv[1]), .rx_crc_err(pv[2]), .halt_clear(pv[3]), .xact_done(pv[4]));
  utd_func_model utd_func_model_inst (.*, .exp_base(td_buffer));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  // Present a descriptor for one cycle; good ones echo the token
  task automatic load(input logic [7:0] pid, input logic [10:0] len, input logic tg,
                      input logic [31:0] bp, input logic good);
    @(posedge sys_clk);
    td_token <= {len, 1'b1, tg, 4'ha, 7'h35, pid}; // Reserved bit set on purpose
    td_buffer <= bp;
    td_load <= 1'b1;
    @(posedge sys_clk);
    td_load <= 1'b0;
    #1;
    if (good) begin
      chk({token_valid, token_pid, token_addr, token_endp, data_pid} ===
        {1'b1, pid, 7'h35, 4'ha, tg ? PID_DATA1 : PID_DATA0}, "token");
    end
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    pv[k] <= 1'b1;
    @(posedge sys_clk);
    pv[k] <= 1'b0;
  endtask
  // A run of ones closed by a zero
  task automatic ones(input int n);
    @(posedge sys_clk);
    rx_bit_valid <= 1'b1;
    rx_bit <= 1'b1;
    repeat (n) @(posedge sys_clk);
    rx_bit <= 1'b0;
    @(posedge sys_clk);
    rx_bit_valid <= 1'b0;
  endtask
  task automatic rx(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'h30 + i[7:0];
    end
    @(posedge sys_clk);
    rx_byte_valid <= 1'b0;
  endtask
  task automatic wait_tx(input logic [15:0] n);
    for (int i = 0; i < 3000; i++) begin
      if (tx_count === n) return;
      @(posedge sys_clk);
    end
    chk(1'b0, "transmit stalled");
    end_of_test;
  endtask
  function automatic logic [31:0] st(input logic c, s, t, input logic [10:0] n);
    return {13'h0, c, s, t, 5'h0, n};
  endfunction
  // End the transaction and compare the status word
  task automatic xact(input logic [31:0] exp);
    pulse(4);
    #1;
    chk({status_wr, busy, halted, status_word} === {3'b100, exp}, "status");
  endtask

  // Received bytes land at buffer start plus index
  always @(posedge sys_clk) begin
    if (token_valid) begin
      wr_cnt <= 0;
    end else if (mem_wr_req) begin
      chk(mem_wr_addr === td_buffer + wr_cnt && mem_wr_data === 8'h30 + wr_cnt[7:0], "wr");
      wr_cnt <= wr_cnt + 1;
    end
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {arst_n, low_speed, td_load, rx_byte_valid, rx_bit_valid, rx_bit} = '0;
    pv = '0;
    td_token = '0;
    td_buffer = '0;
    rx_byte = '0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    chk({busy, halted, data_pid, status_word} === {2'b00, PID_DATA0, 32'h0}, "reset");
    for (int i = 0; i < 3; i++) begin
      load(op_pid[i], op_len[i], i[0], op_buf[i], 1'b1);
      wait_tx(op_n[i]);
      repeat (20) @(posedge sys_clk);
      chk(!mem_rd_req && tx_bad === 16'h0 && tx_count === op_n[i], "payload");
      xact(st(1'b0, 1'b0, 1'b0, 11'(op_n[i] - 16'd1)));
    end
    // Memory too slow after the first byte: payload cut short
    load(PID_OUT, 11'h003, 1'b0, 32'h0000_0200, 1'b1);
    wait_tx(16'd1);
    pv[5] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    pv[5] <= 1'b0;
    chk(!mem_rd_req && !tx_valid && tx_count === 16'd1, "starved");
    xact(st(1'b0, 1'b0, 1'b0, 11'h000));
    // Receive three of five bytes with every error flag raised
    load(PID_IN, 11'h002, 1'b0, 32'h2000_0ffe, 1'b1);
    pulse(0);
    ones(7);
    pulse(2);
    rx(5);
    load(8'h00, 11'h002, 1'b0, 32'h2000_0ffe, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(halted === 1'b0 && busy === 1'b1, "load taken while busy");
    repeat (400) @(posedge sys_clk);
    chk(wr_cnt === 3, "receive count");
    xact(st(1'b1, 1'b1, 1'b1, 11'h002));
    // Low speed, longest length, answer in time, six ones only
    @(posedge sys_clk);
    low_speed <= 1'b1;
    load(PID_IN, LEN_MAX_LEGAL, 1'b1, 32'h0000_0101, 1'b1);
    pulse(0);
    ones(6);
    repeat (1500) @(posedge sys_clk);
    pulse(1);
    repeat (50) @(posedge sys_clk);
    xact(st(1'b0, 1'b0, 1'b0, LEN_NULL));
    @(posedge sys_clk);
    low_speed <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      load(bad_pid[i], bad_len[i], 1'b0, 32'h0, 1'b0);
      chk(token_valid === 1'b0, "bad token taken");
      @(posedge sys_clk);
      #1;
      chk({halted, consist_fail} === 2'b11, "no halt");
      load(PID_OUT, 11'h000, 1'b0, 32'h0, 1'b0);
      chk(token_valid === 1'b0 && busy === 1'b0, "halted took load");
      pulse(3);
      // Halted follows the internal halt one cycle later
      @(posedge sys_clk);
      #1;
      chk({halted, consist_fail} === 2'b00, "halt not cleared");
    end
    end_of_test;
  end
endmodule
